// file: pifb_flag_bank.sv
`include "pifb_params.svh"
`default_nettype none
module pifb_flag_bank
  import pifb_pkg::*;
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [11:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic [31:0]       hrdata,
  output logic              hreadyout,
  output logic              hresp,
  input  wire pifb_events_s evt,
  input  wire logic [5:0]   per_pin_change_flags,
  input  wire logic         serial_rx_level,
  input  wire logic         serial_tx_level,
  output logic              periph_irq_req,
  output logic              global_irq_req
);

  // ****************************************
  // bus slave
  // ****************************************
  pifb_phase_e     phase_ff;
  logic [11:0]     addr_ff;
  logic            wr_ff;
  logic [31:0]     rdata_ff;
  logic            nxt_take;
  logic            wr_cyc;

  assign nxt_take  = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_ff;
  assign wr_cyc    = (phase_ff == PIFB_DATA) && wr_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_ff <= PIFB_IDLE;
      addr_ff  <= 12'h000;
      wr_ff    <= 1'b0;
    end else if (hready) begin
      phase_ff <= nxt_take ? PIFB_DATA : PIFB_IDLE;
      addr_ff  <= haddr;
      wr_ff    <= hwrite;
    end
  end

  function automatic logic is_wr(input logic [11:0] ofs,
                                 input logic        cyc,
                                 input logic [11:0] a);
    is_wr = cyc && (a == ofs);
  endfunction

  // ****************************************
  // enable and control registers
  // ****************************************
  pifb_byte_t ctrl_ff;
  pifb_byte_t en0_ff;
  pifb_byte_t en1_ff;
  pifb_byte_t en2_ff;
  pifb_byte_t en3_ff;
  pifb_byte_t en4_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= `PIFB_RST_REG;
      en0_ff  <= `PIFB_RST_REG;
      en1_ff  <= `PIFB_RST_REG;
      en2_ff  <= `PIFB_RST_REG;
      en3_ff  <= `PIFB_RST_REG;
      en4_ff  <= `PIFB_RST_REG;
    end else begin
      if (is_wr(`PIFB_OFS_CTRL, wr_cyc, addr_ff))
        ctrl_ff <= hwdata[7:0] & `PIFB_MSK_CTRL;
      if (is_wr(`PIFB_OFS_EN0, wr_cyc, addr_ff))
        en0_ff <= hwdata[7:0] & `PIFB_MSK_R0;
      if (is_wr(`PIFB_OFS_EN1, wr_cyc, addr_ff))
        en1_ff <= hwdata[7:0] & `PIFB_MSK_R1;
      if (is_wr(`PIFB_OFS_EN2, wr_cyc, addr_ff))
        en2_ff <= hwdata[7:0] & `PIFB_MSK_R2;
      if (is_wr(`PIFB_OFS_EN3, wr_cyc, addr_ff))
        en3_ff <= hwdata[7:0] & `PIFB_MSK_R3;
      if (is_wr(`PIFB_OFS_EN4, wr_cyc, addr_ff))
        en4_ff <= hwdata[7:0] & `PIFB_MSK_R4;
    end
  end

  // ****************************************
  // sticky flags
  // ****************************************
  // write 0 clears, write 1 leaves; a same-cycle event still sets
  function automatic pifb_byte_t flag_nxt(input pifb_byte_t cur,
                                          input pifb_byte_t set,
                                          input logic       wr,
                                          input pifb_byte_t wd,
                                          input pifb_byte_t msk);
    pifb_byte_t kept;
    kept = wr ? (cur & wd) : cur;
    flag_nxt = (kept | set) & msk;
  endfunction

  pifb_byte_t fl0_ff;
  pifb_byte_t fl1_ff;
  pifb_byte_t fl2_ff;
  pifb_byte_t fl3_ff;
  pifb_byte_t fl4_ff;
  pifb_byte_t nxt_fl0;
  pifb_byte_t nxt_fl1;
  pifb_byte_t nxt_fl2;
  pifb_byte_t nxt_fl3;
  pifb_byte_t nxt_fl4;

  always_comb begin
    // flag sets ignore every enable
    nxt_fl0 = flag_nxt(fl0_ff, evt.r0,
      is_wr(`PIFB_OFS_FL0, wr_cyc, addr_ff), hwdata[7:0],
      `PIFB_MSK_R0W);
    nxt_fl1 = flag_nxt(fl1_ff, evt.r1,
      is_wr(`PIFB_OFS_FL1, wr_cyc, addr_ff), hwdata[7:0],
      `PIFB_MSK_R1W);
    nxt_fl2 = flag_nxt(fl2_ff, evt.r2,
      is_wr(`PIFB_OFS_FL2, wr_cyc, addr_ff), hwdata[7:0],
      `PIFB_MSK_R2);
    nxt_fl3 = flag_nxt(fl3_ff, evt.r3,
      is_wr(`PIFB_OFS_FL3, wr_cyc, addr_ff), hwdata[7:0],
      `PIFB_MSK_R3);
    nxt_fl4 = flag_nxt(fl4_ff, evt.r4,
      is_wr(`PIFB_OFS_FL4, wr_cyc, addr_ff), hwdata[7:0],
      `PIFB_MSK_R4);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fl0_ff <= `PIFB_RST_REG;
      fl1_ff <= `PIFB_RST_REG;
      fl2_ff <= `PIFB_RST_REG;
      fl3_ff <= `PIFB_RST_REG;
      fl4_ff <= `PIFB_RST_REG;
    end else begin
      fl0_ff <= nxt_fl0;
      fl1_ff <= nxt_fl1;
      fl2_ff <= nxt_fl2;
      fl3_ff <= nxt_fl3;
      fl4_ff <= nxt_fl4;
    end
  end

  // ****************************************
  // live views and request gating
  // ****************************************
  pifb_byte_t view0;
  pifb_byte_t view1;
  pifb_byte_t pend_view;
  pifb_byte_t wd_byte;
  logic       pin_change_flag;
  logic       any_req;

  assign pin_change_flag = |per_pin_change_flags;
  assign wd_byte         = hwdata[7:0];
  always_comb begin
    view0 = fl0_ff;
    view0[`PIFB_BIT_PCHG] = pin_change_flag;
    view1 = fl1_ff;
    view1[`PIFB_BIT_RX] = serial_rx_level;
    view1[`PIFB_BIT_TX] = serial_tx_level;
  end

  assign any_req = |(view0 & en0_ff) | |(view1 & en1_ff)
                 | |(fl2_ff & en2_ff) | |(fl3_ff & en3_ff)
                 | |(fl4_ff & en4_ff);
  // request only leaves when the group enable is on
  assign periph_irq_req = any_req && ctrl_ff[`PIFB_BIT_GROUP_EN];
  assign global_irq_req = periph_irq_req
                        && ctrl_ff[`PIFB_BIT_GLOBAL_EN];
  assign pend_view      = {6'h00, global_irq_req, periph_irq_req};

  // ****************************************
  // read mux, registered
  // ****************************************
  pifb_byte_t rd_sel;
  always_comb begin
    case (haddr)
      `PIFB_OFS_CTRL: rd_sel = ctrl_ff;
      `PIFB_OFS_EN0:  rd_sel = en0_ff;
      `PIFB_OFS_EN1:  rd_sel = en1_ff;
      `PIFB_OFS_EN2:  rd_sel = en2_ff;
      `PIFB_OFS_EN3:  rd_sel = en3_ff;
      `PIFB_OFS_EN4:  rd_sel = en4_ff;
      `PIFB_OFS_FL0:  rd_sel = view0;
      `PIFB_OFS_FL1:  rd_sel = view1;
      `PIFB_OFS_FL2:  rd_sel = fl2_ff;
      `PIFB_OFS_FL3:  rd_sel = fl3_ff;
      `PIFB_OFS_FL4:  rd_sel = fl4_ff;
      `PIFB_OFS_PEND: rd_sel = pend_view;
      default:        rd_sel = 8'h00;
    endcase
  end

  // read data sampled at the address phase: one wait-free cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      rdata_ff <= 32'h0000_0000;
    else if (nxt_take && !hwrite)
      rdata_ff <= {24'h00_0000, rd_sel};
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_wr(logic [11:0] ofs);
    wr_cyc && addr_ff == ofs;
  endsequence
  sequence s_no_wr(logic [11:0] ofs);
    !(wr_cyc && addr_ff == ofs);
  endsequence
  sequence s_rd(logic [11:0] ofs);
    nxt_take && !hwrite && haddr == ofs;
  endsequence
  // a source pulse must land the very next cycle
  property p_sets(logic ev, logic fl);
    ev |=> fl;
  endproperty
  property p_hold(logic [11:0] ofs, pifb_byte_t fl);
    s_no_wr(ofs) |=> (fl & $past(fl)) == $past(fl);
  endproperty
  property p_clear(logic [11:0] ofs, pifb_byte_t ev, pifb_byte_t fl);
    s_wr(ofs) |=> (fl & ~($past(wd_byte) | $past(ev))) == 8'h00;
  endproperty
  property p_read(logic [11:0] ofs, pifb_byte_t val);
    s_rd(ofs) |=> hrdata == {24'h00_0000, $past(val)};
  endproperty
  property p_gate(pifb_byte_t fl, pifb_byte_t en);
    |(fl & en) && ctrl_ff[`PIFB_BIT_GROUP_EN] |-> periph_irq_req;
  endproperty
  property p_wr_en(logic [11:0] ofs, pifb_byte_t rg, pifb_byte_t msk);
    s_wr(ofs) |=> rg == ($past(wd_byte) & msk);
  endproperty

  a_flag_set_wins: assert property (
    evt.r0[5] |=> fl0_ff[5]) else $error("timer a event lost");
  a_flag_sticky: assert property (
    fl0_ff[5] && !wr_cyc |=> fl0_ff[5]) else $error("flag dropped");
  a_flag_clear: assert property (
    wr_cyc && addr_ff == `PIFB_OFS_FL2 && !hwdata[4] && !evt.r2[4]
    |=> !fl2_ff[4]) else $error("clear failed");
  a_group_gate: assert property (
    !ctrl_ff[6] |-> !periph_irq_req) else $error("group gate open");
  a_global_gate: assert property (
    global_irq_req |-> ctrl_ff[7] && periph_irq_req)
    else $error("global gate open");
  a_wave_enable: assert property (
    fl4_ff[6] && en4_ff[6] && ctrl_ff[6] |-> periph_irq_req)
    else $error("wavegen request missing");
  a_pin_change: assert property (
    s_rd(`PIFB_OFS_FL0) |=> hrdata[4] == $past(pin_change_flag))
    else $error("pin change view");
  a_unimpl_zero: assert property (
    (fl3_ff & 8'h3c) == 8'h00 && en4_ff[7] == 1'b0)
    else $error("reserved bit set");
  a_rx_level: assert property (
    s_rd(`PIFB_OFS_FL1) |=> hrdata[5] == $past(serial_rx_level))
    else $error("rx view");
  a_ext_edge: assert property (
    evt.r0[0] ##1 s_no_wr(`PIFB_OFS_FL0)
    |=> fl0_ff[0]) else $error("edge flag lost");

  // ****************************************
  // per-source set checks
  // ****************************************
  a_edge_sets: assert property (
    p_sets(evt.r0[0], fl0_ff[0])) else $error("edge flag missed");
  a_gate_close_sets: assert property (
    p_sets(evt.r1[7], fl1_ff[7])) else $error("gate flag missed");
  a_conv_done_sets: assert property (
    p_sets(evt.r1[6], fl1_ff[6])) else $error("conversion flag missed");
  a_sync_done_sets: assert property (
    p_sets(evt.r1[3], fl1_ff[3])) else $error("sync flag missed");
  a_collision_sets: assert property (
    p_sets(evt.r1[2], fl1_ff[2])) else $error("collision flag missed");
  a_match_sets: assert property (
    p_sets(evt.r1[1], fl1_ff[1])) else $error("match flag missed");
  a_ovf_b_sets: assert property (
    p_sets(evt.r1[0], fl1_ff[0])) else $error("overflow flag missed");
  a_comp_b_sets: assert property (
    p_sets(evt.r2[6], fl2_ff[6])) else $error("comparator b missed");
  a_comp_a_sets: assert property (
    p_sets(evt.r2[5], fl2_ff[5])) else $error("comparator a missed");
  a_nv_done_sets: assert property (
    p_sets(evt.r2[4], fl2_ff[4])) else $error("memory flag missed");
  a_rollover_sets: assert property (
    p_sets(evt.r2[0], fl2_ff[0])) else $error("rollover flag missed");
  a_osc_fail_sets: assert property (
    p_sets(evt.r3[7], fl3_ff[7])) else $error("osc fail missed");
  a_clk_switch_sets: assert property (
    p_sets(evt.r3[6], fl3_ff[6])) else $error("clock switch missed");
  a_cell_b_sets: assert property (
    p_sets(evt.r3[1], fl3_ff[1])) else $error("logic cell b missed");
  a_cell_a_sets: assert property (
    p_sets(evt.r3[0], fl3_ff[0])) else $error("logic cell a missed");
  a_shutdown_sets: assert property (
    p_sets(evt.r4[6], fl4_ff[6])) else $error("shutdown flag missed");
  a_capcmp_b_sets: assert property (
    p_sets(evt.r4[1], fl4_ff[1])) else $error("capcmp b missed");
  a_capcmp_a_sets: assert property (
    p_sets(evt.r4[0], fl4_ff[0])) else $error("capcmp a missed");

  // ****************************************
  // hold, clear, read, gate and write checks
  // ****************************************
  a_hold_zero: assert property (
    p_hold(`PIFB_OFS_FL0, fl0_ff)) else $error("flag zero dropped");
  a_hold_one: assert property (
    p_hold(`PIFB_OFS_FL1, fl1_ff)) else $error("flag one dropped");
  a_hold_two: assert property (
    p_hold(`PIFB_OFS_FL2, fl2_ff)) else $error("flag two dropped");
  a_hold_three: assert property (
    p_hold(`PIFB_OFS_FL3, fl3_ff)) else $error("flag three dropped");
  a_hold_four: assert property (
    p_hold(`PIFB_OFS_FL4, fl4_ff)) else $error("flag four dropped");
  a_clear_zero: assert property (
    p_clear(`PIFB_OFS_FL0, evt.r0, fl0_ff)) else $error("flag zero kept");
  a_clear_one: assert property (
    p_clear(`PIFB_OFS_FL1, evt.r1, fl1_ff)) else $error("flag one kept");
  a_clear_two: assert property (
    p_clear(`PIFB_OFS_FL2, evt.r2, fl2_ff)) else $error("flag two kept");
  a_clear_three: assert property (
    p_clear(`PIFB_OFS_FL3, evt.r3, fl3_ff)) else $error("flag three kept");
  a_clear_four: assert property (
    p_clear(`PIFB_OFS_FL4, evt.r4, fl4_ff)) else $error("flag four kept");
  a_read_ctrl: assert property (
    p_read(`PIFB_OFS_CTRL, ctrl_ff)) else $error("control read");
  a_read_en0: assert property (
    p_read(`PIFB_OFS_EN0, en0_ff)) else $error("enable zero read");
  a_read_en1: assert property (
    p_read(`PIFB_OFS_EN1, en1_ff)) else $error("enable one read");
  a_read_en2: assert property (
    p_read(`PIFB_OFS_EN2, en2_ff)) else $error("enable two read");
  a_read_en3: assert property (
    p_read(`PIFB_OFS_EN3, en3_ff)) else $error("enable three read");
  a_read_en4: assert property (
    p_read(`PIFB_OFS_EN4, en4_ff)) else $error("enable four read");
  a_read_fl0: assert property (
    p_read(`PIFB_OFS_FL0, view0)) else $error("flag zero read");
  a_read_fl1: assert property (
    p_read(`PIFB_OFS_FL1, view1)) else $error("flag one read");
  a_read_fl2: assert property (
    p_read(`PIFB_OFS_FL2, fl2_ff)) else $error("flag two read");
  a_read_fl3: assert property (
    p_read(`PIFB_OFS_FL3, fl3_ff)) else $error("flag three read");
  a_read_fl4: assert property (
    p_read(`PIFB_OFS_FL4, fl4_ff)) else $error("flag four read");
  a_read_pend: assert property (
    p_read(`PIFB_OFS_PEND, pend_view)) else $error("pending read");
  a_gate_zero: assert property (
    p_gate(view0, en0_ff)) else $error("group zero request missing");
  a_gate_one: assert property (
    p_gate(view1, en1_ff)) else $error("group one request missing");
  a_gate_two: assert property (
    p_gate(fl2_ff, en2_ff)) else $error("group two request missing");
  a_gate_three: assert property (
    p_gate(fl3_ff, en3_ff)) else $error("group three request missing");
  a_gate_four: assert property (
    p_gate(fl4_ff, en4_ff)) else $error("group four request missing");
  a_wr_ctrl: assert property (
    p_wr_en(`PIFB_OFS_CTRL, ctrl_ff, `PIFB_MSK_CTRL))
    else $error("control write");
  a_wr_en0: assert property (
    p_wr_en(`PIFB_OFS_EN0, en0_ff, `PIFB_MSK_R0))
    else $error("enable zero write");
  a_wr_en1: assert property (
    p_wr_en(`PIFB_OFS_EN1, en1_ff, `PIFB_MSK_R1))
    else $error("enable one write");
  a_wr_en2: assert property (
    p_wr_en(`PIFB_OFS_EN2, en2_ff, `PIFB_MSK_R2))
    else $error("enable two write");
  a_wr_en3: assert property (
    p_wr_en(`PIFB_OFS_EN3, en3_ff, `PIFB_MSK_R3))
    else $error("enable three write");
  a_wr_en4: assert property (
    p_wr_en(`PIFB_OFS_EN4, en4_ff, `PIFB_MSK_R4))
    else $error("enable four write");
endmodule
`default_nettype wire

// file: pifb_params.svh
// Functional notes
// - flags set regardless of any enable
// - peripheral group enable gates every request
// - enable four bit 6 gates wavegen
// - enable four bits 1,0 gate capcmp
// - timer a overflow sets sticky flag
// - pin change flag is or of pins
// - external edge sets sticky flag
// - unimplemented bits read zero
// - timer b gate close sets flag
// - conversion done sets flag
// - serial rx flag mirrors buffer state
// - sync port completion sets sticky flag
// - bus collision sets sticky flag
// - timer c match, timer b overflow
// - comparator b and a set flags
// - nonvolatile task done sets flag
// - accumulator oscillator rollover sets flag
// - oscillator failure sets flag
// - clock switch condition sets flag
// - logic cells b and a set flags
// - wavegen shutdown sets flag
// - capcmp events set flags
// - global enable gates only the global request; the peripheral request ignores it
// - enable zero gates flag zero sources
`ifndef PIFB_PARAMS_SVH
`define PIFB_PARAMS_SVH
`define PIFB_OFS_CTRL 12'h000
`define PIFB_OFS_EN0 12'h004
`define PIFB_OFS_EN1 12'h008
`define PIFB_OFS_EN2 12'h00c
`define PIFB_OFS_EN3 12'h010
`define PIFB_OFS_EN4 12'h014
`define PIFB_OFS_FL0 12'h018
`define PIFB_OFS_FL1 12'h01c
`define PIFB_OFS_FL2 12'h020
`define PIFB_OFS_FL3 12'h024
`define PIFB_OFS_FL4 12'h028
`define PIFB_OFS_PEND 12'h02c
`define PIFB_MSK_CTRL 8'hc0
`define PIFB_MSK_R0 8'h31
`define PIFB_MSK_R0W 8'h21
`define PIFB_MSK_R1 8'hff
`define PIFB_MSK_R1W 8'hcf
`define PIFB_MSK_R2 8'h71
`define PIFB_MSK_R3 8'hc3
`define PIFB_MSK_R4 8'h43
`define PIFB_BIT_GLOBAL_EN 7
`define PIFB_BIT_GROUP_EN 6
`define PIFB_BIT_RX 5
`define PIFB_BIT_TX 4
`define PIFB_BIT_PCHG 4
`define PIFB_RST_REG 8'h00
`endif

// file: pifb_pkg.sv
`default_nettype none
package pifb_pkg;
  typedef logic [7:0] pifb_byte_t;
  // raw one-cycle event pulses per flag register
  typedef struct packed {
    pifb_byte_t r0;
    pifb_byte_t r1;
    pifb_byte_t r2;
    pifb_byte_t r3;
    pifb_byte_t r4;
  } pifb_events_s;
  typedef enum logic [0:0] {
    PIFB_IDLE = 1'b0,
    PIFB_DATA = 1'b1
  } pifb_phase_e;
endpackage
`default_nettype wire

// file: pifb_periph_model.sv
`default_nettype none
module pifb_periph_model
  import pifb_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       fire,
  input  wire logic [2:0] sel,
  input  wire logic [7:0] pat,
  output pifb_events_s    evt
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // peripheral condition pulses
  // ****************************************
  // one cycle only: a held level would hide a missed clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt <= '0;
    end else if (fire) begin
      evt <= pifb_events_s'({32'h0, pat} << (8 * (4 - sel)));
    end else begin
      evt <= '0;
    end
  end
endmodule
`default_nettype wire

// file: testbench.sv
`include "pifb_params.svh"
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench
  import pifb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite, fire, rx, tx, rd_pend, hrdy, hresp;
  logic preq, greq;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, sel;
  logic [31:0] hwdata, hrdata, exp_v;
  logic [5:0] pins;
  logic [7:0] pat, r;
  logic [7:0] hw_msk [5] = '{8'h21, 8'hcf, 8'h71, 8'hc3, 8'h43};
  pifb_events_s evt;
  logic [31:0] q[$];
  int fail_count = 0;
  int comparisons = 0;
  pifb_flag_bank DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
    .hresp(hresp), .evt(evt), .per_pin_change_flags(pins),
    .serial_rx_level(rx), .serial_tx_level(tx), .periph_irq_req(preq),
    .global_irq_req(greq));
  pifb_periph_model peers (.hclk(hclk), .hresetn(hresetn), .fire(fire),
    .sel(sel), .pat(pat), .evt(evt));
  // ****************************************
  // bus master and result monitor
  // ****************************************
  initial begin
    hclk = 0;
    forever #50 hclk = ~hclk;
  end
  task automatic bus(input logic [11:0] a, input logic w,
                     input logic [31:0] d, input logic p);
    @(posedge hclk);
    hsel <= 1; haddr <= a; hwrite <= w; htrans <= 2'b10; fire <= p;
    do @(posedge hclk); while (hrdy !== 1'b1);
    hsel <= 0; htrans <= 2'b00; hwdata <= d; fire <= 0; rd_pend <= !w;
    do @(posedge hclk); while (hrdy !== 1'b1);
    rd_pend <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    q.push_back({24'h0, e});
    bus(a, 0, '0, 0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(a, 1, {24'h0, d}, 0);
  endtask
  task automatic pulse(input logic [2:0] s, input logic [7:0] p);
    sel <= s; pat <= p;
    // unmapped carrier write: control must stay as software left it
    bus(12'h100, 1, 32'h0, 1);
  endtask
  task automatic irq(input logic p, input logic g);
    @(negedge hclk);
    `CHK(preq, p)
    `CHK(greq, g)
  endtask
  // upper bits must read zero on every word
  always @(posedge hclk) if (rd_pend && hrdy === 1'b1) begin
    exp_v = q.pop_front();
    `CHK(hrdata, exp_v)
    `CHK(hresp, 1'b0)
  end
  task conclude;
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge hclk);
    fail_count++;
    conclude();
  end
  initial begin
    hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'b010;
    hwdata = 0; fire = 0; sel = 0; pat = 0; pins = 0; rx = 0; tx = 0;
    rd_pend = 0;
    void'($urandom(15));
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    for (int i = 0; i < 12; i++) rd(12'(4 * i), 8'h00);
    rd(12'h100, 8'h00);
    wr(`PIFB_OFS_EN4, 8'hff);
    rd(`PIFB_OFS_EN4, 8'h43);
    wr(`PIFB_OFS_EN4, 8'h00);
    for (int i = 0; i < 5; i++) begin
      r = 8'($urandom) | 8'h21;
      pulse(3'(i), r);
      rd(`PIFB_OFS_FL0 + 12'(4 * i), r & hw_msk[i]);
      wr(`PIFB_OFS_FL0 + 12'(4 * i), 8'h00);
      rd(`PIFB_OFS_FL0 + 12'(4 * i), 8'h00);
    end
    pins <= 6'($urandom) | 6'h01;
    rd(`PIFB_OFS_FL0, 8'h10);
    pins <= 6'h00;
    rd(`PIFB_OFS_FL0, 8'h00);
    rx <= 1; tx <= 1;
    wr(`PIFB_OFS_FL1, 8'h00);
    rd(`PIFB_OFS_FL1, 8'h30);
    rx <= 0; tx <= 0;
    rd(`PIFB_OFS_FL1, 8'h00);
    // event lands on the clearing write: must survive
    sel <= 3'd4; pat <= 8'h40;
    bus(`PIFB_OFS_FL4, 1, 32'h0, 1);
    rd(`PIFB_OFS_FL4, 8'h40);
    wr(`PIFB_OFS_EN4, 8'h40);
    irq(0, 0);
    wr(`PIFB_OFS_CTRL, 8'h40);
    irq(1, 0);
    wr(`PIFB_OFS_CTRL, 8'hc0);
    irq(1, 1);
    rd(`PIFB_OFS_PEND, 8'h03);
    wr(`PIFB_OFS_EN4, 8'h03);
    irq(0, 0);
    pulse(3'd4, 8'h02);
    irq(1, 1);
    wr(`PIFB_OFS_FL4, 8'h00);
    pulse(3'd4, 8'h01);
    irq(1, 1);
    wr(`PIFB_OFS_FL4, 8'h00);
    irq(0, 0);
    for (int i = 0; i < 4; i++) begin
      wr(`PIFB_OFS_EN0 + 12'(4 * i), 8'hff);
      irq(0, 0);
      pulse(3'(i), 8'h01);
      irq(1, 1);
      wr(`PIFB_OFS_FL0 + 12'(4 * i), 8'h00);
      wr(`PIFB_OFS_EN0 + 12'(4 * i), 8'h00);
    end
    conclude();
  end
endmodule
`default_nettype wire
